// ### rtl/eeprom_pkg.sv
// Shared constants and types for the serial protected memory
package eeprom_pkg;
   localparam int ADDR_W = 17;
   localparam int PAGE_W = 7;
   localparam int FIFO_DEPTH = 32;
   localparam int SYNC_STAGES = 3;
   // Opcodes with the don't-care bit 3 removed: {op[7:4], op[2:0]}
   localparam logic [6:0] OP_SET_WEL = 7'h06;
   localparam logic [6:0] OP_CLR_WEL = 7'h04;
   localparam logic [6:0] OP_ST_READ = 7'h05;
   localparam logic [6:0] OP_ST_WRITE = 7'h01;
   localparam logic [6:0] OP_ARR_READ = 7'h03;
   localparam logic [6:0] OP_ARR_WRITE = 7'h02;
   // Status bit positions
   localparam int SR_BUSY = 0;
   localparam int SR_WEL = 1;
   localparam int SR_BPL = 2;
   localparam int SR_BPH = 3;
   localparam int SR_PEN = 7;
   localparam logic [7:0] SR_DURING_WRITE = 8'hFF;
   localparam logic [2:0] SR_UNUSED = 3'h0;
   // Protected range bases
   localparam logic [ADDR_W-1:0] PROT_QUARTER = 17'h18000;
   localparam logic [ADDR_W-1:0] PROT_HALF = 17'h10000;
   // Self-timed write cycle
   localparam int TWC_US = 5000;
   localparam int CLK_KHZ = 20000;
   localparam int TWC_CYCLES = TWC_US * CLK_KHZ / 1000;
   typedef struct packed {
      logic wp_n;
      logic si;
      logic sck;
      logic cs_n;
   } pins_t;
   localparam pins_t PINS_RESET = 4'h9;
   typedef struct packed {
      logic pen;
      logic [1:0] bp;
   } nv_t;
   localparam nv_t NV_RESET = 3'h0;
   typedef enum logic [2:0] {
      S_OPC = 3'b000,
      S_ADDR = 3'b001,
      S_RDAT = 3'b011,
      S_WDAT = 3'b010,
      S_SRD = 3'b110,
      S_SWR = 3'b111,
      S_IGN = 3'b101
   } ser_t;
   typedef enum logic [1:0] {
      W_IDLE = 2'b00,
      W_DRAIN = 2'b01,
      W_WAIT = 2'b11
   } wr_t;
endpackage

// ### rtl/byte_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module byte_fifo import eeprom_pkg::*; #(
   parameter int WIDTH = 8,
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW:0] wr_ff, rd_ff, nxt_wr, nxt_rd;
   logic push, pop;

   assign in_ready = (wr_ff[PW] != rd_ff[PW])
                   ? (wr_ff[PW-1:0] != rd_ff[PW-1:0]) : 1'b1;
   assign out_valid = (wr_ff != rd_ff);
   assign out_data = mem[rd_ff[PW-1:0]];

   always_comb begin
      push = in_valid & in_ready;
      pop = out_valid & out_ready;
      nxt_wr = push ? wr_ff + 1'b1 : wr_ff;
      nxt_rd = pop ? rd_ff + 1'b1 : rd_ff;
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wr_ff <= '0;
         rd_ff <= '0;
      end else begin
         wr_ff <= nxt_wr;
         rd_ff <= nxt_rd;
      end
   end

   always_ff @(posedge clock) begin
      if (push) begin
         mem[wr_ff[PW-1:0]] <= in_data;
      end
   end
endmodule // byte_fifo

// ### rtl/spi_eeprom_prot.sv
// Serial memory slave: command decode, write latch, protection, array
//
// Contract
// - Opcode, address and data move MSB first; opcode held in 8-bit register.
// - Opcode 0000X110 sets write latch, 0000X100 clears it; bit 3 ignored.
// - Opcode 0000X101 shifts out the status register.
// - Opcode 0000X001 writes protect level bits and protect-enable bit.
// - Opcode 0000X011 starts array read, 0000X010 starts array write.
// - Write latch is clear after reset; master must set it first.
// - Clearing the write latch disables programming regardless of protect pin.
// - Status bit 0 is 1 during internal write cycle, else 0.
// - Status bit 1 mirrors the write latch.
// - Bits 6..4 read zero when idle; all bits read one during write.
// - Protect bits select none, top quarter, top half or whole array.
// - Array writes into protected range are rejected.
// - Protect bits are nonvolatile, need write latch and timed busy cycle; here arst_n still clears them to NV_RESET.
// - Hardware protection active only with pin low and enable bit set.
// - Hardware protection blocks all status writes and protected array writes.
// - Enable bit cannot be cleared while pin low and protection active.
// - After read address, serial input ignored; data shifted out bit 7 first.
// - Read address increments after each byte while selected.
// - Read address wraps from highest address to zero.
// - Unknown opcode: ignore input, output stays off until next select.
// - While deselected, input ignored and output off.
// - Write latch clears automatically when a programming cycle ends.
`timescale 1ns/100ps
module spi_eeprom_prot import eeprom_pkg::*; #(
   parameter int WRITE_CYCLES = TWC_CYCLES,
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic si,
   input wire logic wp_n,
   output logic so,
   output logic so_oe_n
);
   localparam int TW = $clog2(WRITE_CYCLES) + 1;
   localparam int NP = $bits(pins_t);

   logic [7:0] mem [2**ADDR_W];

   // Pin synchronisers and edge detection
   pins_t raw, flt_ff, nxt_flt, prev_ff;
   logic sck_rise, sck_fall, cs_rise;
   assign raw = '{wp_n: wp_n, si: si, sck: sck, cs_n: cs_n};

   for (genvar i = 0; i < NP; i++) begin : g_sync
      logic [SYNC_STAGES-1:0] sync_ff;
      always_ff @(posedge clock or negedge arst_n) begin
         if (!arst_n) begin
            sync_ff <= {SYNC_STAGES{PINS_RESET[i]}};
         end else begin
            sync_ff <= {sync_ff[SYNC_STAGES-2:0], raw[i]};
         end
      end
      always_comb begin
         nxt_flt[i] = (sync_ff[1] == sync_ff[2]) ? sync_ff[2] : flt_ff[i];
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         flt_ff <= PINS_RESET;
         prev_ff <= PINS_RESET;
      end else begin
         flt_ff <= nxt_flt;
         prev_ff <= flt_ff;
      end
   end

   assign sck_rise = flt_ff.sck & ~prev_ff.sck;
   assign sck_fall = ~flt_ff.sck & prev_ff.sck;
   assign cs_rise = flt_ff.cs_n & ~prev_ff.cs_n;

   // Write engine state, declared here for the decoder
   wr_t wst_ff, nxt_wst;
   logic wel_ff, nxt_wel;
   nv_t nv_ff, nxt_nv;
   logic commit_ff, nxt_commit;
   logic busy, busy_any, hw_prot;
   logic [7:0] status_byte;

   assign busy_any = (wst_ff != W_IDLE);
   assign busy = busy_any & commit_ff;
   assign hw_prot = ~flt_ff.wp_n & nv_ff.pen;
   assign status_byte = busy ? SR_DURING_WRITE
                      : {nv_ff.pen, SR_UNUSED, nv_ff.bp, wel_ff, 1'b0};

   // FIFO between the serial side and the array
   logic fifo_push, fifo_in_ready, fifo_pop, fifo_out_valid;
   logic [7:0] fifo_out;

   // Serial side
   ser_t st_ff, nxt_st;
   logic [2:0] cnt_ff, nxt_cnt;
   logic [7:0] shift_ff, nxt_shift;
   logic [1:0] abyte_ff, nxt_abyte;
   logic [ADDR_W-1:0] addr_ff, nxt_addr;
   logic got_ff, nxt_got;
   logic rd_op_ff, nxt_rd_op;
   logic [7:0] sdata_ff, nxt_sdata;
   logic so_ff, nxt_so, oe_n_ff, nxt_oe_n;
   logic set_wel, clr_wel, start_arr, start_st;
   logic [7:0] rx, txb;
   logic [6:0] op;

   always_comb begin
      nxt_st = st_ff;
      nxt_cnt = cnt_ff;
      nxt_shift = shift_ff;
      nxt_abyte = abyte_ff;
      nxt_addr = addr_ff;
      nxt_got = got_ff;
      nxt_rd_op = rd_op_ff;
      nxt_sdata = sdata_ff;
      nxt_so = so_ff;
      nxt_oe_n = oe_n_ff;
      set_wel = 1'b0;
      clr_wel = 1'b0;
      fifo_push = 1'b0;
      start_arr = 1'b0;
      start_st = 1'b0;
      rx = {shift_ff[6:0], flt_ff.si};
      op = {rx[7:4], rx[2:0]};
      txb = (st_ff == S_SRD) ? status_byte : mem[addr_ff];
      if (flt_ff.cs_n) begin
         // Deselected: restart framing, release output
         nxt_st = S_OPC;
         nxt_cnt = 3'h0;
         nxt_abyte = 2'h0;
         nxt_got = 1'b0;
         nxt_oe_n = 1'b1;
         if (cs_rise && cnt_ff == 3'h0 && got_ff) begin
            start_arr = (st_ff == S_WDAT);
            start_st = (st_ff == S_SWR);
         end
      end else if (sck_rise && st_ff != S_IGN) begin
         nxt_shift = rx;
         nxt_cnt = cnt_ff + 3'h1;
         if (cnt_ff == 3'h7) begin
            case (st_ff)
               S_OPC: begin
                  nxt_st = S_IGN;
                  if (busy_any) begin
                     if (op == OP_ST_READ) begin
                        nxt_st = S_SRD;
                     end
                  end else begin
                     case (op)
                        OP_SET_WEL: set_wel = 1'b1;
                        OP_CLR_WEL: clr_wel = 1'b1;
                        OP_ST_READ: nxt_st = S_SRD;
                        OP_ST_WRITE: begin
                           if (wel_ff) begin
                              nxt_st = S_SWR;
                           end
                        end
                        OP_ARR_READ: begin
                           nxt_st = S_ADDR;
                           nxt_rd_op = 1'b1;
                        end
                        OP_ARR_WRITE: begin
                           if (wel_ff) begin
                              nxt_st = S_ADDR;
                              nxt_rd_op = 1'b0;
                           end
                        end
                        default: nxt_st = S_IGN;
                     endcase
                  end
               end
               S_ADDR: begin
                  // Upper address bits fall off the top
                  nxt_addr = {addr_ff[ADDR_W-9:0], rx};
                  nxt_abyte = abyte_ff + 2'h1;
                  if (abyte_ff == 2'h2) begin
                     nxt_st = rd_op_ff ? S_RDAT : S_WDAT;
                  end
               end
               S_RDAT: nxt_addr = addr_ff + 1'b1;
               S_WDAT: begin
                  fifo_push = fifo_in_ready;
                  nxt_got = 1'b1;
               end
               S_SWR: begin
                  if (!got_ff) begin
                     nxt_sdata = rx;
                     nxt_got = 1'b1;
                  end
               end
               default: nxt_st = st_ff;
            endcase
         end
      end else if (sck_fall && (st_ff == S_RDAT || st_ff == S_SRD)) begin
         nxt_oe_n = 1'b0;
         nxt_so = txb[3'h7 - cnt_ff];
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         st_ff <= S_OPC;
         cnt_ff <= 3'h0;
         shift_ff <= 8'h00;
         abyte_ff <= 2'h0;
         addr_ff <= '0;
         got_ff <= 1'b0;
         rd_op_ff <= 1'b0;
         sdata_ff <= 8'h00;
         so_ff <= 1'b0;
         oe_n_ff <= 1'b1;
      end else begin
         st_ff <= nxt_st;
         cnt_ff <= nxt_cnt;
         shift_ff <= nxt_shift;
         abyte_ff <= nxt_abyte;
         addr_ff <= nxt_addr;
         got_ff <= nxt_got;
         rd_op_ff <= nxt_rd_op;
         sdata_ff <= nxt_sdata;
         so_ff <= nxt_so;
         oe_n_ff <= nxt_oe_n;
      end
   end

   assign so = so_ff;
   assign so_oe_n = oe_n_ff;

   byte_fifo #(
      .WIDTH(8),
      .DEPTH(DEPTH)
   ) u_fifo (
      .clock(clock),
      .arst_n(arst_n),
      .in_data(rx),
      .in_valid(fifo_push),
      .in_ready(fifo_in_ready),
      .out_data(fifo_out),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_pop)
   );

   // Write engine: drains the FIFO, then runs the timed cycle
   logic [ADDR_W-1:0] waddr_ff, nxt_waddr;
   logic is_st_ff, nxt_is_st;
   nv_t pend_ff, nxt_pend;
   logic [TW-1:0] timer_ff, nxt_timer;
   logic mem_we, in_prot;

   function automatic logic protected_at(input logic [1:0] bp,
                                         input logic [ADDR_W-1:0] a);
      case (bp)
         2'h0: protected_at = 1'b0;
         2'h1: protected_at = (a >= PROT_QUARTER);
         2'h2: protected_at = (a >= PROT_HALF);
         default: protected_at = 1'b1;
      endcase
   endfunction

   always_comb begin
      nxt_wst = wst_ff;
      nxt_waddr = waddr_ff;
      nxt_commit = commit_ff;
      nxt_is_st = is_st_ff;
      nxt_pend = pend_ff;
      nxt_timer = timer_ff;
      nxt_nv = nv_ff;
      nxt_wel = wel_ff;
      fifo_pop = 1'b0;
      mem_we = 1'b0;
      in_prot = protected_at(nv_ff.bp, waddr_ff);
      if (clr_wel) begin
         nxt_wel = 1'b0;
      end else if (set_wel) begin
         nxt_wel = 1'b1;
      end
      case (wst_ff)
         W_IDLE: begin
            nxt_timer = '0;
            if (start_arr) begin
               nxt_wst = W_DRAIN;
               nxt_commit = wel_ff;
               nxt_is_st = 1'b0;
               nxt_waddr = addr_ff;
            end else if (start_st && wel_ff && !hw_prot) begin
               nxt_wst = W_WAIT;
               nxt_commit = 1'b1;
               nxt_is_st = 1'b1;
               nxt_pend = '{pen: sdata_ff[SR_PEN],
                            bp: {sdata_ff[SR_BPH], sdata_ff[SR_BPL]}};
            end
         end
         W_DRAIN: begin
            if (fifo_out_valid) begin
               fifo_pop = 1'b1;
               mem_we = commit_ff & ~in_prot;
               nxt_waddr = {waddr_ff[ADDR_W-1:PAGE_W],
                            waddr_ff[PAGE_W-1:0] + 1'b1};
            end else begin
               nxt_wst = commit_ff ? W_WAIT : W_IDLE;
            end
         end
         W_WAIT: begin
            nxt_timer = timer_ff + 1'b1;
            if (timer_ff == TW'(WRITE_CYCLES - 1)) begin
               nxt_wst = W_IDLE;
               nxt_commit = 1'b0;
               nxt_wel = 1'b0;
               if (is_st_ff) begin
                  nxt_nv = pend_ff;
               end
            end
         end
         default: nxt_wst = W_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wst_ff <= W_IDLE;
         waddr_ff <= '0;
         commit_ff <= 1'b0;
         is_st_ff <= 1'b0;
         pend_ff <= NV_RESET;
         timer_ff <= '0;
         nv_ff <= NV_RESET;
         wel_ff <= 1'b0;
      end else begin
         wst_ff <= nxt_wst;
         waddr_ff <= nxt_waddr;
         commit_ff <= nxt_commit;
         is_st_ff <= nxt_is_st;
         pend_ff <= nxt_pend;
         timer_ff <= nxt_timer;
         nv_ff <= nxt_nv;
         wel_ff <= nxt_wel;
      end
   end

   always_ff @(posedge clock) begin
      if (mem_we) begin
         mem[waddr_ff] <= fifo_out;
      end
   end
endmodule // spi_eeprom_prot

// ### tb/spi_eeprom_prot_properties.sv
// Port-level checker for the serial memory slave
`timescale 1ns/100ps
module spi_eeprom_prot_properties (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic si,
   input wire logic wp_n,
   input wire logic so,
   input wire logic so_oe_n
);
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   a_deselect_off: assert property (cs_n [*6] |-> so_oe_n)
      else $error("so driven while deselected");
   a_opcode_quiet: assert property ($fell(cs_n) |-> so_oe_n [*8])
      else $error("so driven during opcode");
   a_oe_needs_cs: assert property (
      $fell(so_oe_n) |-> !cs_n && !$past(cs_n, 8))
      else $error("so enabled without selection");
   a_oe_after_fall: assert property (
      $fell(so_oe_n) |-> $past(sck, 6) && !$past(sck, 2))
      else $error("so enabled off a clock fall");
   a_so_quiet_high: assert property (sck [*4] |-> $stable(so))
      else $error("so moved in clock high phase");
   a_so_moves_low: assert property (
      $changed(so) && !so_oe_n && !$past(so_oe_n) |-> !$past(sck, 2))
      else $error("so moved away from a clock fall");
   a_oe_rise_cs: assert property ($rose(so_oe_n) |-> $past(cs_n, 2))
      else $error("so released while selected");
   a_oe_holds: assert property (!so_oe_n && !cs_n |=> !so_oe_n)
      else $error("so dropped during stream");
   cover property ($fell(so_oe_n));
   cover property ($rose(so_oe_n));
   cover property (sck [*4]);
endmodule // spi_eeprom_prot_properties
bind spi_eeprom_prot spi_eeprom_prot_properties u_props (.clock(clock),
   .arst_n(arst_n), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n),
   .so(so), .so_oe_n(so_oe_n));

// ### tb/spi_master_model.sv
// Serial bus master model driving the memory slave in mode 0
`timescale 1ns/100ps
module spi_master_model (
   input wire logic clock,
   input wire logic so,
   output logic cs_n,
   output logic sck,
   output logic si
);
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      si = 1'b0;
   end
   task automatic edges(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic select();
      edges(1);
      cs_n = 1'b0;
      edges(4);
   endtask
   // Data set in the low phase; slave output taken one clock into the
   // high phase, since the slave answers a filtered fall five clocks late
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         si = tx[i];
         edges(4);
         sck = 1'b1;
         edges(1);
         rx[i] = so;
         edges(3);
         sck = 1'b0;
      end
   endtask
   // Select drops inside the low phase right after the last bit
   task automatic deselect();
      edges(2);
      cs_n = 1'b1;
      edges(8);
   endtask
endmodule // spi_master_model

// ### tb/tb_top.sv
// Self-checking bench for the serial memory slave
`timescale 1ns/100ps
module tb_top;
   localparam int WCYC = 300;
   logic clock, arst_n, wp_n, cs_n, sck, si, so, so_oe_n;
   logic [7:0] rx;
   logic so_line;
   int err_total, total_checks;
   spi_eeprom_prot #(.WRITE_CYCLES(WCYC)) u_dut (.clock(clock),
      .arst_n(arst_n), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n),
      .so(so), .so_oe_n(so_oe_n));
   spi_master_model u_master (.clock(clock), .so(so_line), .cs_n(cs_n),
      .sck(sck), .si(si));
   // Released output shows the inverse of its last level to the master
   assign so_line = so_oe_n ? ~so : so;
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   task automatic complete_run();
      $display("Checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic op(input logic [7:0] code);
      u_master.select();
      u_master.xfer(code, rx);
      u_master.deselect();
   endtask
   task automatic status(input logic [7:0] exp);
      u_master.select();
      u_master.xfer(8'h05, rx);
      u_master.xfer(8'hA5, rx);
      u_master.deselect();
      chk(rx, exp);
   endtask
   task automatic addr(input logic [7:0] code, input logic [23:0] a);
      u_master.select();
      u_master.xfer(code, rx);
      u_master.xfer(a[23:16], rx);
      u_master.xfer(a[15:8], rx);
      u_master.xfer(a[7:0], rx);
   endtask
   task automatic wr(input logic [23:0] a, input logic [7:0] d0, d1);
      op(8'h06);
      addr(8'h02, a);
      u_master.xfer(d0, rx);
      u_master.xfer(d1, rx);
      u_master.deselect();
   endtask
   task automatic swr(input logic [7:0] v);
      op(8'h0E);
      u_master.select();
      u_master.xfer(8'h01, rx);
      u_master.xfer(v, rx);
      u_master.deselect();
   endtask
   task automatic settle();
      u_master.edges(WCYC + 40);
   endtask
   // Serial input carries junk while data streams out
   task automatic rd(input logic [23:0] a, input logic [7:0] e0, e1);
      addr(8'h03, a);
      u_master.xfer(8'hFF, rx);
      chk(rx, e0);
      u_master.xfer(8'h00, rx);
      chk(rx, e1);
      u_master.deselect();
   endtask
   task automatic t_latch();
      status(8'h00);
      op(8'h0E);
      status(8'h02);
      wp_n = 1'b0;
      op(8'h0C);
      status(8'h00);
      wp_n = 1'b1;
   endtask
   task automatic t_write();
      wr(24'h000010, 8'h11, 8'h12);
      status(8'hFF);
      settle();
      status(8'h00);
      addr(8'h0A, 24'h000010);
      u_master.xfer(8'h77, rx);
      u_master.deselect();
      settle();
      rd(24'h000010, 8'h11, 8'h12);
      rd(24'hFE0010, 8'h11, 8'h12);
      wr(24'h01FFFF, 8'hC3, 8'h5E);
      settle();
      wr(24'h000000, 8'h3C, 8'h4B);
      settle();
      rd(24'h01FFFF, 8'hC3, 8'h3C);
   endtask
   task automatic t_unknown();
      u_master.select();
      u_master.xfer(8'h07, rx);
      u_master.xfer(8'h06, rx);
      chk({7'h00, so_oe_n}, 8'h01);
      u_master.deselect();
      status(8'h00);
   endtask
   task automatic t_block();
      wr(24'h018000, 8'h55, 8'h56);
      settle();
      swr(8'h04);
      status(8'hFF);
      settle();
      status(8'h04);
      wr(24'h018000, 8'h99, 8'h98);
      settle();
      wr(24'h017FFF, 8'h66, 8'h67);
      settle();
      rd(24'h017FFF, 8'h66, 8'h55);
   endtask
   task automatic t_hw();
      swr(8'h84);
      settle();
      status(8'h84);
      wp_n = 1'b0;
      swr(8'h00);
      settle();
      op(8'h04);
      status(8'h84);
      wp_n = 1'b1;
      swr(8'h00);
      settle();
      status(8'h00);
   endtask
   initial begin
      repeat (60000) @(posedge clock);
      err_total++;
      complete_run();
   end
   initial begin
      err_total = 0;
      total_checks = 0;
      arst_n = 1'b0;
      wp_n = 1'b1;
      repeat (2) @(posedge clock);
      #1 arst_n = 1'b1;
      u_master.edges(5);
      t_latch();
      t_write();
      t_unknown();
      t_block();
      t_hw();
      complete_run();
   end
endmodule // tb_top
